// File: hw/adcsr_consts.vh
/*
  Constants for the converter's serial result output in the internal
  clock, continuous conversion mode.
  Assumes inclusion by bare name from the design files under hw/.
*/
`ifndef ADCSR_CONSTS_VH
`define ADCSR_CONSTS_VH

// Clock rate and power-on reset length.
`define ADCSR_CLK_MHZ      50
`define ADCSR_POR_TIME_US  1000
`define ADCSR_POR_CYCLES   (`ADCSR_POR_TIME_US * `ADCSR_CLK_MHZ)
`define ADCSR_POR_W        16
`define ADCSR_POR_STEP     16'h0001

// Pin synchronisers: clock pin and select pin, both idle high.
`define ADCSR_SYNC_N       2
`define ADCSR_SYNC_SCK     0
`define ADCSR_SYNC_CS      1

// Serial clock: half period in system clocks.
`define ADCSR_SCK_HALF     3'h4
`define ADCSR_HALF_W       3
`define ADCSR_HALF_STEP    3'h1

// Output frame: conversion-done bit plus result bits.
`define ADCSR_RES_W        18
`define ADCSR_FRAME_W      19
`define ADCSR_EDGE_W       5
`define ADCSR_FRAME_EDGES  5'h13
`define ADCSR_EDGE_STEP    5'h01

// Controller states.
`define ADCSR_ST_POR       2'h0
`define ADCSR_ST_CONV      2'h1
`define ADCSR_ST_OUT       2'h2
`define ADCSR_ST_EXT       2'h3

`endif

// File: hw/adcsr_serial_out.v
/*
  Serial result output of a two-channel converter, internal serial clock,
  two-wire continuous conversion mode. Drives the clock and data pins.
  Assumes the converter core on clk pulses convDone with convResult valid
  and starts a conversion on convStart; pin inputs are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adcsr_consts.vh"

module adcsr_serial_out #(
  parameter [`ADCSR_POR_W-1:0] POR_CYCLES = `ADCSR_POR_CYCLES
) (
  // Clock and reset.
  input  wire                   clk,
  input  wire                   nrst,
  // Serial clock pin.
  input  wire                   sckI,
  output wire                   sckO,
  output wire                   sckOe,
  output wire                   sckPullEn,
  // Serial data pin and select.
  input  wire                   csN,
  output wire                   sdoO,
  output wire                   sdoOe,
  // Converter core.
  input  wire                   convDone,
  input  wire [`ADCSR_RES_W-1:0] convResult,
  output wire                   convStart,
  output wire                   extClkMode
);

////////////////////////////////////////////////////////////////////////////
  reg  [1:0]                  state_q;
  reg  [1:0]                  state_d;
  reg  [`ADCSR_POR_W-1:0]     porCnt_q;
  reg  [`ADCSR_POR_W-1:0]     porCnt_d;
  reg  [`ADCSR_HALF_W-1:0]    halfCnt_q;
  reg  [`ADCSR_HALF_W-1:0]    halfCnt_d;
  reg  [`ADCSR_EDGE_W-1:0]    edgeCnt_q;
  reg  [`ADCSR_EDGE_W-1:0]    edgeCnt_d;
  reg  [`ADCSR_FRAME_W-1:0]   shift_q;
  reg  [`ADCSR_FRAME_W-1:0]   shift_d;
  reg                         sck_q;
  reg                         sck_d;
  reg                         sdo_q;
  reg                         sdo_d;
  reg                         start_q;
  reg                         start_d;
  reg  [`ADCSR_SYNC_N-1:0]    sync1_q;
  reg  [`ADCSR_SYNC_N-1:0]    sync2_q;
  wire [`ADCSR_SYNC_N-1:0]    pinIn;
  wire                        sckSynced;
  wire                        csSynced;
  wire                        porDone;
  wire                        halfDone;
  wire                        lastEdge;

////////////////////////////////////////////////////////////////////////////
  // State decode is needed by several outputs.
  function stateIs;
    input [1:0] cur;
    input [1:0] want;
    begin
      stateIs = (cur == want);
    end
  endfunction

////////////////////////////////////////////////////////////////////////////
  // Pins cross into clk through two flops before any use. Both reset to
  // the idle high level so no false edge follows reset.
  assign pinIn[`ADCSR_SYNC_SCK] = sckI;
  assign pinIn[`ADCSR_SYNC_CS]  = csN;

  genvar gi;
  generate
    for (gi = 0; gi < `ADCSR_SYNC_N; gi = gi + 1) begin : gSync
      always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
          sync1_q[gi] <= 1'b1;
          sync2_q[gi] <= 1'b1;
        end else begin
          sync1_q[gi] <= pinIn[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign sckSynced = sync2_q[`ADCSR_SYNC_SCK];
  assign csSynced  = sync2_q[`ADCSR_SYNC_CS];

////////////////////////////////////////////////////////////////////////////
  assign porDone  = (porCnt_q == POR_CYCLES - `ADCSR_POR_STEP);
  assign halfDone = (halfCnt_q == `ADCSR_SCK_HALF - `ADCSR_HALF_STEP);
  assign lastEdge = (edgeCnt_q == `ADCSR_FRAME_EDGES);

  always @* begin
    state_d   = state_q;
    porCnt_d  = porCnt_q;
    halfCnt_d = halfCnt_q;
    edgeCnt_d = edgeCnt_q;
    shift_d   = shift_q;
    sck_d     = sck_q;
    sdo_d     = sdo_q;
    start_d   = 1'b0;
    case (state_q)
      `ADCSR_ST_POR: begin
        porCnt_d = porCnt_q + `ADCSR_POR_STEP;
        if (porDone) begin
          // The pull-up is the only driver here, so a low level means
          // the pin is held or loaded low from outside.
          if (sckSynced) begin
            state_d = `ADCSR_ST_CONV;
            start_d = 1'b1;
          end else begin
            state_d = `ADCSR_ST_EXT;
          end
        end
      end
      `ADCSR_ST_CONV: begin
        sck_d = 1'b1;
        sdo_d = 1'b1;
        if (convDone) begin
          state_d   = `ADCSR_ST_OUT;
          shift_d   = {1'b0, convResult};
          sck_d     = 1'b0;
          sdo_d     = 1'b0;
          halfCnt_d = {`ADCSR_HALF_W{1'b0}};
          edgeCnt_d = {`ADCSR_EDGE_W{1'b0}};
        end
      end
      `ADCSR_ST_OUT: begin
        if (halfDone) begin
          halfCnt_d = {`ADCSR_HALF_W{1'b0}};
        end else begin
          halfCnt_d = halfCnt_q + `ADCSR_HALF_STEP;
        end
        if (halfDone) begin
          if (lastEdge) begin
            // Data rises a half period after the last rising edge so
            // the receiver keeps hold time on the final bit.
            state_d = `ADCSR_ST_CONV;
            sdo_d   = 1'b1;
            start_d = 1'b1;
          end else if (!sck_q) begin
            sck_d     = 1'b1;
            edgeCnt_d = edgeCnt_q + `ADCSR_EDGE_STEP;
          end else begin
            sck_d   = 1'b0;
            shift_d = {shift_q[`ADCSR_FRAME_W-2:0], 1'b1};
            sdo_d   = shift_q[`ADCSR_FRAME_W-2];
          end
        end
      end
      default: begin
        // External clock mode is handled elsewhere; this end releases the clock pin but still drives data high while selected.
        sck_d = 1'b1;
        sdo_d = 1'b1;
      end
    endcase
  end

////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q   <= `ADCSR_ST_POR;
      porCnt_q  <= {`ADCSR_POR_W{1'b0}};
      halfCnt_q <= {`ADCSR_HALF_W{1'b0}};
      edgeCnt_q <= {`ADCSR_EDGE_W{1'b0}};
      shift_q   <= {`ADCSR_FRAME_W{1'b1}};
      sck_q     <= 1'b1;
      sdo_q     <= 1'b1;
      start_q   <= 1'b0;
    end else begin
      state_q   <= state_d;
      porCnt_q  <= porCnt_d;
      halfCnt_q <= halfCnt_d;
      edgeCnt_q <= edgeCnt_d;
      shift_q   <= shift_d;
      sck_q     <= sck_d;
      sdo_q     <= sdo_d;
      start_q   <= start_d;
    end
  end

////////////////////////////////////////////////////////////////////////////
  // Enables are decoded from state, the data enable also from select; data values come from flops.
  assign sckO       = sck_q;
  assign sckOe      = stateIs(state_q, `ADCSR_ST_CONV) ||
                      stateIs(state_q, `ADCSR_ST_OUT);
  assign sckPullEn  = stateIs(state_q, `ADCSR_ST_POR);
  assign sdoO       = sdo_q;
  assign sdoOe      = !csSynced &&
                      !stateIs(state_q, `ADCSR_ST_POR);
  assign convStart  = start_q;
  assign extClkMode = stateIs(state_q, `ADCSR_ST_EXT);

endmodule
`default_nettype wire

// File: test/adcsr_serial_out_assertions.sv
/* Pin timing checks for adcsr_serial_out.
   Allows the core to pulse convDone while no conversion runs. */
`timescale 1ns/1ns
`default_nettype none
module adcsr_checker (
  input wire logic        clk, nrst, sckI, sckO, sckOe, sckPullEn, csN,
  input wire logic        sdoO, sdoOe, convDone, convStart, extClkMode,
  input wire logic [17:0] convResult
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Set from a conversion start until the done that ends it, so a done
  // pulse during a frame is not taken for a real one.
  logic inConv;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) inConv <= 1'b0;
    else if (convStart) inConv <= 1'b1;
    else if (convDone) inConv <= 1'b0;
  end
  sequence doneSeen;
    convDone && inConv && sckOe && sckO && sdoO;
  endsequence
  a_done_low: assert property (doneSeen |=> !sckO && !sdoO)
    else $error("pins not low after done");
  a_frame_len: assert property (doneSeen |-> ##153 convStart)
    else $error("frame length wrong");
  a_conv_high: assert property (convStart |=> sckO && sdoO && sckOe)
    else $error("pins not high in conversion");
  a_low_width: assert property ($fell(sckO) |-> !sckO[*4] ##1 sckO)
    else $error("clock low phase wrong");
  a_data_edge: assert property ($changed(sdoO) |-> $fell(sckO) || convStart)
    else $error("data moved off falling edge");
  a_por_quiet: assert property (sckPullEn |-> !sckOe && !convStart)
    else $error("drive during power-on");
  a_ext_quiet: assert property (extClkMode |-> !sckOe && !convStart)
    else $error("drive in external mode");
  a_strap_pick: assert property ($fell(sckPullEn) |-> ##[0:3] (convStart || extClkMode))
    else $error("no mode chosen");
  a_cs_float: assert property (csN[*5] |-> !sdoOe)
    else $error("data driven while deselected");
endmodule
bind adcsr_serial_out adcsr_checker chk_i (.*);
`default_nettype wire

// File: test/adcsr_rx_model.sv
/* Receiving controller: shifts the data pin in on rising clock pin edges.
   Assumes the bench resolves both pins. */
`timescale 1ns/1ns
`default_nettype none
module adcsr_rx_model (
  input  wire logic        nrst, sckPin, sdoPin,
  output var  logic [18:0] word,
  output var  logic        got
);
  logic [4:0] cnt;
  // The nineteenth rising edge completes a word; select stays low.
  always @(posedge sckPin or negedge nrst) begin
    if (!nrst) begin
      cnt <= 5'h00; got <= 1'b0; word <= 19'h00000;
    end else begin
      word <= {word[17:0], sdoPin};
      got  <= (cnt == 5'h12);
      cnt  <= (cnt == 5'h12) ? 5'h00 : cnt + 5'h01;
    end
  end
endmodule
`default_nettype wire

// File: test/testbench.sv
/* Self-checking bench for adcsr_serial_out with a listening receiver.
   Assumes a short power-on count of 20 cycles. */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        clk = 0, nrst = 0, strap = 1, csN = 0, convDone = 0;
  logic [17:0] res = 0;
  logic [18:0] q[$];
  wire         sckO, sckOe, sdoO, sdoOe, convStart, extClkMode, got, pullEn;
  wire  [18:0] word;
  // Weak pull-up keeps the clock pin high unless strapped low.
  wire         sckPin = sckOe ? sckO : strap;
  wire         sdoPin = sdoOe ? sdoO : ~sdoO;
  int          err_count = 0, num_checks = 0;
  always #10 clk = ~clk;
  adcsr_serial_out #(.POR_CYCLES(16'h0014)) DUT (.clk(clk), .nrst(nrst),
    .sckI(sckPin), .sckO(sckO), .sckOe(sckOe), .sckPullEn(pullEn), .csN(csN),
    .sdoO(sdoO), .sdoOe(sdoOe), .convDone(convDone), .convResult(res),
    .convStart(convStart), .extClkMode(extClkMode));
  adcsr_rx_model RX (.nrst(nrst), .sckPin(sckPin), .sdoPin(sdoPin),
    .word(word), .got(got));
  task chk(input string nm, input logic [18:0] s, e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task report_and_stop;
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task waitStart;
    for (int i = 0; i < 300 && convStart !== 1'b1; i++) cyc(1);
    if (convStart !== 1'b1) begin
      err_count++;
      report_and_stop;
    end
    cyc(1);
  endtask
  task pulse(input logic [17:0] v);
    res = v; convDone = 1; cyc(1); convDone = 0;
  endtask
  // Compare a half cycle later so the word has settled with the flag.
  always @(posedge got) begin
    @(negedge clk);
    chk("frame", word, q.pop_front());
  end
  initial begin
    void'($urandom(31208));
    cyc(3); nrst = 1;
    waitStart;
    repeat (3) begin
      cyc(1 + $urandom % 9);
      pulse(18'($urandom)); q.push_back({1'b0, res});
      cyc(40); pulse(~res); // Ignored mid-frame.
      waitStart;
    end
    csN = 1; cyc(6); chk("sdoOe", sdoOe, 0); csN = 0;
    cyc(200); chk("pending", q.size(), 0);
    chk("sckPullEn", pullEn, 0);
    strap = 0; nrst = 0; cyc(3); nrst = 1;
    cyc(5); chk("sckPullEn", pullEn, 1);
    cyc(25); chk("extClkMode", extClkMode, 1);
    chk("sckOe", sckOe, 0);
    report_and_stop;
  end
endmodule
`default_nettype wire
